/* File: core/amci_defs.svh */
`ifndef AMCI_DEFS_SVH
`define AMCI_DEFS_SVH
`define AMCI_OFF_COMMON 8'h04
`define AMCI_OFF_TASK2 8'h0c
`define AMCI_OFF_XCMD 8'h14
`define AMCI_OFF_YCMD 8'h1c
`define AMCI_OFF_XSTAT 8'h40
`define AMCI_OFF_YSTAT 8'h44
`define AMCI_OFF_UNIT 8'h48
`define AMCI_OFF_EXPIN 8'h4c
`define AMCI_OFF_EXPOUT 8'h50
`define AMCI_OFF_CFG 8'h54
`define AMCI_OFF_ENV 8'h58
`define AMCI_B_ERR_RESET 14
`define AMCI_B_EXP_READ 15
`define AMCI_B_OPT_LO 11
`define AMCI_B_DSTOP 0
`define AMCI_B_OSEARCH 1
`define AMCI_B_ORETURN 2
`define AMCI_B_JOG 3
`define AMCI_B_PRESET 5
`define AMCI_B_ABSINIT 6
`define AMCI_B_JOGDIR 13
`define AMCI_S_BUSY 1
`define AMCI_S_NO_ORIGIN 3
`define AMCI_S_REF_ORIGIN 4
`define AMCI_S_MOVING 5
`define AMCI_S_NEG 6
`define AMCI_S_LIMITED 7
`define AMCI_S_ERROR 8
`define AMCI_S_OVR_ON 9
`define AMCI_OP_CYCLES 32'd16
`endif

/* File: core/amci_pkg.sv */
package amci_pkg;
	typedef enum logic [2:0] {
		AMCI_IDLE = 3'h0,
		AMCI_SEARCH = 3'h1,
		AMCI_OFFSET = 3'h3,
		AMCI_RETURN = 3'h2,
		AMCI_JOG = 3'h6,
		AMCI_DECEL = 3'h7,
		AMCI_ONESHOT = 3'h5
	} amci_state_e;
	typedef struct packed {
		logic abs_axis;
		logic has_offset;
		logic run_cmd;
		logic servo_lock;
	} amci_cfg_s;
endpackage : amci_pkg

/* File: core/amci_top.sv */
`timescale 1ns/10ps
`include "amci_defs.svh"
// Notes on behaviour
// [R01] Error reset rising edge clears error; error type clears with it.
// [R02] Host holds error reset until error flag reads low.
// [R03] Expansion input copy refreshes only while request and read-completed are high.
// [R04] Five optional input bits appear in the task two word, bits 11 to 15.
// [R05] Deceleration stop edge stops search, return, jog; accepted while busy.
// [R06] While stop bit is high all other manual commands are refused.
// [R07] New manual command accepted only after previous command bit dropped.
// [R08] Origin search starts on rising edge, stops on falling edge.
// [R09] With offset configured, a point-to-point offset move follows origin detection.
// [R10] Origin search ignored while busy; host holds until no-origin clears.
// [R11] Absolute encoder axis performs origin return instead of search.
// [R12] Reference return starts on rise, stops on fall.
// [R13] Return before origin fixed raises error; ignored while busy.
// [R14] Jog moves while bit high, decelerates on release, ignored while busy.
// [R15] With origin fixed, jogging is confined within software limits.
// [R16] Jog direction sampled at jog rise; 1 means negative.
// [R17] Preset edge loads position from expansion data, fixes reference origin.
// [R18] Preset checks limits, skips on error, ignored busy, not aborted by stop.
// [R19] Absolute axis preset changes internal position only; servo lock reloads.
// [R20] Absolute init reads encoder, zeroes position, completes despite early drop.
// [R21] Absolute init errors under run command or servo lock; skipped incremental.
// [R22] Second axis has identical command bits in its own word.
// [R23] Edges found by comparing each refreshed word with its previous sample.
module amci_axis (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] cmd,
	input wire logic [31:0] preset_val,
	input wire amci_pkg::amci_cfg_s cfg,
	input wire logic err_clear,
	input wire logic [31:0] lim_lo,
	input wire logic [31:0] lim_hi,
	input wire logic [31:0] enc_pos,
	output logic [15:0] status,
	output logic [31:0] pos
);
	amci_pkg::amci_state_e st_reg;
	logic [15:0] prev_reg;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [31:0] cnt_reg;
	logic busy;
	logic origin_reg;
	logic neg_reg;
	logic err_reg;
	logic limited_reg;
	logic lock_prev_reg;
	logic held_reg;
	logic [31:0] step;
	assign rise = cmd & ~prev_reg; // [R23]
	assign fall = ~cmd & prev_reg; // [R23]
	assign busy = st_reg != amci_pkg::AMCI_IDLE;
	assign step = neg_reg ? (pos - 32'd1) : (pos + 32'd1); // [R16]
	always_ff @(posedge aclk) begin
		if (!aresetn)
			prev_reg <= 16'h0000;
		else
			prev_reg <= cmd;
	end
	// Held bit blocks new commands until the search, return, jog, preset and init bits all drop
	always_ff @(posedge aclk) begin
		if (!aresetn)
			held_reg <= 1'b0;
		else if (busy)
			held_reg <= 1'b1;
		else if ((cmd & 16'h006e) == 16'h0000)
			held_reg <= 1'b0; // [R07]
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lock_prev_reg <= 1'b0;
		else
			lock_prev_reg <= cfg.servo_lock;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= amci_pkg::AMCI_IDLE;
			cnt_reg <= 32'h0000_0000;
			origin_reg <= 1'b0;
			neg_reg <= 1'b0;
			err_reg <= 1'b0;
			limited_reg <= 1'b0;
			pos <= 32'h0000_0000;
		end else begin
			if (err_clear)
				err_reg <= 1'b0; // [R01]
			if (cfg.abs_axis && cfg.servo_lock && !lock_prev_reg)
				pos <= enc_pos; // [R19]
			case (st_reg)
			amci_pkg::AMCI_IDLE: begin
				limited_reg <= 1'b0;
				cnt_reg <= 32'h0000_0000;
				if (cmd[`AMCI_B_DSTOP] || held_reg) begin
					// Refused: stop interlock or previous command still high [R06] [R07]
				end else if (rise[`AMCI_B_OSEARCH]) begin
					if (cfg.abs_axis)
						st_reg <= amci_pkg::AMCI_RETURN; // [R11]
					else
						st_reg <= amci_pkg::AMCI_SEARCH; // [R08] [R10]
				end else if (rise[`AMCI_B_ORETURN]) begin
					if (!origin_reg)
						err_reg <= 1'b1; // [R13]
					else
						st_reg <= amci_pkg::AMCI_RETURN; // [R12]
				end else if (rise[`AMCI_B_JOG]) begin
					neg_reg <= cmd[`AMCI_B_JOGDIR]; // [R16]
					st_reg <= amci_pkg::AMCI_JOG; // [R14]
				end else if (rise[`AMCI_B_PRESET]) begin
					if ($signed(preset_val) < $signed(lim_lo) ||
						$signed(preset_val) > $signed(lim_hi))
						err_reg <= 1'b1; // [R18]
					else begin
						pos <= preset_val; // [R17] [R19]
						origin_reg <= 1'b1; // [R17]
						st_reg <= amci_pkg::AMCI_ONESHOT;
					end
				end else if (rise[`AMCI_B_ABSINIT]) begin
					if (!cfg.abs_axis) begin
						// Incremental axis: no effect [R21]
					end else if (cfg.run_cmd || cfg.servo_lock)
						err_reg <= 1'b1; // [R21]
					else begin
						pos <= 32'h0000_0000; // [R20]
						origin_reg <= 1'b1;
						st_reg <= amci_pkg::AMCI_ONESHOT; // [R20]
					end
				end
			end
			amci_pkg::AMCI_SEARCH: begin
				cnt_reg <= cnt_reg + 32'd1;
				if (rise[`AMCI_B_DSTOP] || fall[`AMCI_B_OSEARCH])
					st_reg <= amci_pkg::AMCI_DECEL; // [R05] [R08]
				else if (cnt_reg == `AMCI_OP_CYCLES) begin
					pos <= 32'h0000_0000;
					cnt_reg <= 32'h0000_0000;
					if (cfg.has_offset)
						st_reg <= amci_pkg::AMCI_OFFSET; // [R09]
					else begin
						origin_reg <= 1'b1;
						st_reg <= amci_pkg::AMCI_IDLE;
					end
				end
			end
			amci_pkg::AMCI_OFFSET: begin
				cnt_reg <= cnt_reg + 32'd1;
				if (rise[`AMCI_B_DSTOP] || fall[`AMCI_B_OSEARCH])
					st_reg <= amci_pkg::AMCI_DECEL; // [R05]
				else if (cnt_reg == `AMCI_OP_CYCLES) begin
					pos <= 32'h0000_0000; // [R09]
					origin_reg <= 1'b1;
					st_reg <= amci_pkg::AMCI_IDLE;
				end
			end
			amci_pkg::AMCI_RETURN: begin
				cnt_reg <= cnt_reg + 32'd1;
				if (rise[`AMCI_B_DSTOP] || fall[`AMCI_B_ORETURN] ||
					(cfg.abs_axis && fall[`AMCI_B_OSEARCH]))
					st_reg <= amci_pkg::AMCI_DECEL; // [R05] [R12]
				else if (cnt_reg == `AMCI_OP_CYCLES) begin
					pos <= 32'h0000_0000;
					origin_reg <= 1'b1;
					st_reg <= amci_pkg::AMCI_IDLE;
				end
			end
			amci_pkg::AMCI_JOG: begin
				if (rise[`AMCI_B_DSTOP] || !cmd[`AMCI_B_JOG])
					st_reg <= amci_pkg::AMCI_DECEL; // [R05] [R14]
				else if (origin_reg &&
					((neg_reg && $signed(pos) <= $signed(lim_lo)) ||
					(!neg_reg && $signed(pos) >= $signed(lim_hi))))
					limited_reg <= 1'b1; // [R15]
				else begin
					limited_reg <= 1'b0;
					pos <= step; // [R15]
				end
			end
			amci_pkg::AMCI_DECEL: begin
				st_reg <= amci_pkg::AMCI_IDLE;
			end
			amci_pkg::AMCI_ONESHOT: begin
				// Preset and init run to completion, stop ignored [R18] [R20]
				st_reg <= amci_pkg::AMCI_IDLE;
			end
			default: st_reg <= amci_pkg::AMCI_IDLE;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			status <= 16'h0008;
		else begin
			status <= 16'h0000;
			status[`AMCI_S_BUSY] <= busy;
			status[`AMCI_S_NO_ORIGIN] <= !origin_reg;
			status[`AMCI_S_REF_ORIGIN] <= origin_reg;
			status[`AMCI_S_MOVING] <= busy && st_reg != amci_pkg::AMCI_ONESHOT;
			status[`AMCI_S_NEG] <= neg_reg;
			status[`AMCI_S_LIMITED] <= limited_reg;
			status[`AMCI_S_ERROR] <= err_reg;
		end
	end
endmodule : amci_axis

module amci_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [4:0] opt_in_pins,
	input wire logic exp_read_done
);
	logic [15:0] common_reg;
	logic [15:0] task2_reg;
	logic [15:0] xcmd_reg;
	logic [15:0] ycmd_reg;
	logic [31:0] expout_reg;
	logic [31:0] expin_reg;
	logic [31:0] env_reg;
	logic [3:0] cfg_reg;
	logic [15:0] xstat;
	logic [15:0] ystat;
	logic [31:0] xpos;
	logic [31:0] ypos;
	logic [4:0] opt_s1_reg;
	logic [4:0] opt_s2_reg;
	logic done_s1_reg;
	logic done_s2_reg;
	logic [15:0] prev_common_reg;
	logic unit_err_reg;
	logic [7:0] err_type_reg;
	logic err_clear;
	logic [7:0] aw_reg;
	logic aw_have_reg;
	logic [31:0] w_reg;
	logic [3:0] ws_reg;
	logic w_have_reg;
	logic wr_go;
	logic [31:0] rd_word;
	logic rd_hit;
	amci_pkg::amci_cfg_s xcfg;
	amci_pkg::amci_cfg_s ycfg;
	assign xcfg = {cfg_reg[0], cfg_reg[1], env_reg[0], env_reg[1]};
	assign ycfg = {cfg_reg[2], cfg_reg[3], env_reg[2], env_reg[3]};
	assign err_clear = common_reg[`AMCI_B_ERR_RESET] &
		~prev_common_reg[`AMCI_B_ERR_RESET]; // [R01] [R23]
	assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opt_s1_reg <= 5'h00;
			opt_s2_reg <= 5'h00;
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			prev_common_reg <= 16'h0000;
		end else begin
			opt_s1_reg <= opt_in_pins;
			opt_s2_reg <= opt_s1_reg;
			done_s1_reg <= exp_read_done;
			done_s2_reg <= done_s1_reg;
			prev_common_reg <= common_reg;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			expin_reg <= 32'h0000_0000;
		else if (common_reg[`AMCI_B_EXP_READ] && done_s2_reg)
			expin_reg <= {xpos[15:0], ypos[15:0]}; // [R03]
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_err_reg <= 1'b0;
			err_type_reg <= 8'h00;
		end else begin
			// Mirrors axis flags so the type drops together with the flag
			unit_err_reg <= xstat[`AMCI_S_ERROR] || ystat[`AMCI_S_ERROR]; // [R01]
			err_type_reg <= {6'h00, ystat[`AMCI_S_ERROR], xstat[`AMCI_S_ERROR]}; // [R01]
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_reg <= 8'h00;
			w_have_reg <= 1'b0;
			w_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_reg)
				`AMCI_OFF_COMMON, `AMCI_OFF_TASK2, `AMCI_OFF_XCMD, `AMCI_OFF_YCMD,
				`AMCI_OFF_EXPOUT, `AMCI_OFF_CFG, `AMCI_OFF_ENV: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) &&
				!(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) &&
				!(s_axi_bvalid && !s_axi_bready);
		end
	end
	// Register writes, low half-word lanes for 16-bit words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			common_reg <= 16'h0000;
			task2_reg <= 16'h0000;
			xcmd_reg <= 16'h0000;
			ycmd_reg <= 16'h0000;
			expout_reg <= 32'h0000_0000;
			cfg_reg <= 4'h0;
			env_reg <= 32'h0000_0000;
		end else if (wr_go) begin
			case (aw_reg)
			`AMCI_OFF_COMMON: begin
				if (ws_reg[0]) common_reg[7:0] <= w_reg[7:0];
				if (ws_reg[1]) common_reg[15:8] <= w_reg[15:8];
			end
			`AMCI_OFF_TASK2: begin
				if (ws_reg[0]) task2_reg[7:0] <= w_reg[7:0];
				if (ws_reg[1]) task2_reg[15:8] <= w_reg[15:8];
			end
			`AMCI_OFF_XCMD: begin
				if (ws_reg[0]) xcmd_reg[7:0] <= w_reg[7:0];
				if (ws_reg[1]) xcmd_reg[15:8] <= w_reg[15:8];
			end
			`AMCI_OFF_YCMD: begin
				if (ws_reg[0]) ycmd_reg[7:0] <= w_reg[7:0];
				if (ws_reg[1]) ycmd_reg[15:8] <= w_reg[15:8];
			end
			`AMCI_OFF_EXPOUT: begin
				for (int i = 0; i < 4; i++)
					if (ws_reg[i]) expout_reg[i*8 +: 8] <= w_reg[i*8 +: 8];
			end
			`AMCI_OFF_CFG: if (ws_reg[0]) cfg_reg <= w_reg[3:0];
			`AMCI_OFF_ENV: begin
				for (int i = 0; i < 4; i++)
					if (ws_reg[i]) env_reg[i*8 +: 8] <= w_reg[i*8 +: 8];
			end
			default: ;
			endcase
		end
	end
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
		`AMCI_OFF_COMMON: rd_word = {16'h0000, common_reg};
		`AMCI_OFF_TASK2: rd_word = {16'h0000, opt_s2_reg, task2_reg[10:0]}; // [R04]
		`AMCI_OFF_XCMD: rd_word = {16'h0000, xcmd_reg};
		`AMCI_OFF_YCMD: rd_word = {16'h0000, ycmd_reg}; // [R22]
		`AMCI_OFF_XSTAT: rd_word = {16'h0000, xstat};
		`AMCI_OFF_YSTAT: rd_word = {16'h0000, ystat};
		`AMCI_OFF_UNIT: rd_word = {16'h0000, err_type_reg, 7'h00, unit_err_reg};
		`AMCI_OFF_EXPIN: rd_word = expin_reg;
		`AMCI_OFF_EXPOUT: rd_word = expout_reg;
		`AMCI_OFF_CFG: rd_word = {28'h0000000, cfg_reg};
		`AMCI_OFF_ENV: rd_word = env_reg;
		default: rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
	amci_axis u_x (
		.aclk(aclk), .aresetn(aresetn), .cmd(xcmd_reg), .preset_val(expout_reg),
		.cfg(xcfg), .err_clear(err_clear), .lim_lo(32'h8000_0000),
		.lim_hi(32'h7fff_ffff), .enc_pos(expout_reg), .status(xstat), .pos(xpos)
	);
	amci_axis u_y (
		.aclk(aclk), .aresetn(aresetn), .cmd(ycmd_reg), .preset_val(expout_reg),
		.cfg(ycfg), .err_clear(err_clear), .lim_lo(32'h8000_0000),
		.lim_hi(32'h7fff_ffff), .enc_pos(expout_reg), .status(ystat), .pos(ypos)
	); // [R22]
endmodule : amci_top

/* File: bench/amci_monitor.sv */
`timescale 1ns/10ps
module amci_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [4:0] opt_in_pins
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] rd_addr;
	logic [2:0] opt_age;
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
		end
	end
	// Cycles the optional inputs have been steady
	always_ff @(posedge aclk) begin
		if (!aresetn || $changed(opt_in_pins)) begin
			opt_age <= 3'h0;
		end else if (opt_age != 3'h7) begin
			opt_age <= opt_age + 3'h1;
		end
	end
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence aw_w_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	wr_answer_a: assert property (aw_w_take |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read response missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer not held");
	rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
	unmapped_rd_a: assert property (ar_take ##0 s_axi_araddr > 8'h58 |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pending");
	opt_in_a: assert property ($rose(s_axi_rvalid) && rd_addr == 8'h0c && opt_age == 3'h7 |->
		s_axi_rdata[15:11] == opt_in_pins)
		else $error("optional inputs misread");
endmodule : amci_monitor

bind amci_top amci_monitor u_amci_monitor (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .opt_in_pins(opt_in_pins));

/* File: bench/amci_host_bfm.sv */
`timescale 1ns/10ps
// Host side: command words stay as last written until the next write
module amci_host_bfm (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	output logic hang
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, hang} = '0;
	end
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		r = bresp;
		bready <= 1'b0;
		hang <= hang | (n >= 100);
	endtask : wr
	// Slow mode: rready raised only after lag cycles
	task rd(input logic [7:0] a, input int lag, output logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n >= lag && !rready) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 100);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		hang <= hang | (n >= 100);
	endtask : rd
endmodule : amci_host_bfm

/* File: bench/tb.sv */
`timescale 1ns/10ps
`include "amci_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
	logic aclk, aresetn, exp_read_done, hang;
	logic [4:0] opt_in_pins;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int failures, n_checks;
	amci_top u_amci_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.opt_in_pins(opt_in_pins), .exp_read_done(exp_read_done));
	amci_host_bfm u_amci_host_bfm (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hang(hang));
	task w(input logic [7:0] a, input logic [31:0] v);
		u_amci_host_bfm.wr(a, v, r);
	endtask : w
	task rq(input logic [7:0] a);
		u_amci_host_bfm.rd(a, 0, d, r);
	endtask : rq
	task poll(input logic [7:0] a, input int b, input logic v);
		for (int i = 0; i < 60; i++) begin
			rq(a);
			if (d[b] === v) break;
		end
	endtask : poll
	task t_regs();
		u_amci_host_bfm.wr(8'h60, 32'h1, r);
		`CHK("unmapped write", 2'h2, r)
		u_amci_host_bfm.rd(8'h60, 3, d, r);
		`CHK("unmapped read", 34'h2_0000_0000, {r, d})
		w(`AMCI_OFF_XCMD, 32'h2000);
		u_amci_host_bfm.rd(`AMCI_OFF_XCMD, 4, d, r);
		`CHK("x command readback", 16'h2000, d[15:0])
		w(`AMCI_OFF_XCMD, 32'h0);
	endtask : t_regs
	task t_err();
		w(`AMCI_OFF_XCMD, 32'h4);
		poll(`AMCI_OFF_XSTAT, `AMCI_S_ERROR, 1'b1);
		`CHK("return without origin", 1'b1, d[`AMCI_S_ERROR])
		rq(`AMCI_OFF_UNIT);
		`CHK("unit error", 2'h3, {d[8], d[0]})
		w(`AMCI_OFF_XCMD, 32'h0);
		w(`AMCI_OFF_COMMON, 32'h4000);
		poll(`AMCI_OFF_UNIT, 0, 1'b0);
		`CHK("error cleared", 9'h0, {d[15:8], d[0]})
		w(`AMCI_OFF_COMMON, 32'h0);
	endtask : t_err
	task t_search();
		w(`AMCI_OFF_XCMD, 32'h2);
		poll(`AMCI_OFF_XSTAT, `AMCI_S_BUSY, 1'b1);
		`CHK("search busy", 1'b1, d[`AMCI_S_BUSY])
		poll(`AMCI_OFF_XSTAT, `AMCI_S_NO_ORIGIN, 1'b0);
		`CHK("origin found", 1'b0, d[`AMCI_S_NO_ORIGIN])
		w(`AMCI_OFF_XCMD, 32'h0);
		poll(`AMCI_OFF_XSTAT, `AMCI_S_BUSY, 1'b0);
	endtask : t_search
	task t_jog();
		w(`AMCI_OFF_XCMD, 32'h9);
		rq(`AMCI_OFF_XSTAT);
		`CHK("jog under stop", 1'b0, d[`AMCI_S_MOVING])
		w(`AMCI_OFF_XCMD, 32'h0);
		w(`AMCI_OFF_XCMD, 32'h2008);
		poll(`AMCI_OFF_XSTAT, `AMCI_S_MOVING, 1'b1);
		`CHK("jog negative", 2'h3, {d[`AMCI_S_MOVING], d[`AMCI_S_NEG]})
		w(`AMCI_OFF_XCMD, 32'h8);
		rq(`AMCI_OFF_XSTAT);
		`CHK("direction kept", 1'b1, d[`AMCI_S_NEG])
		w(`AMCI_OFF_XCMD, 32'h9);
		poll(`AMCI_OFF_XSTAT, `AMCI_S_MOVING, 1'b0);
		`CHK("stop while busy", 1'b0, d[`AMCI_S_MOVING])
		w(`AMCI_OFF_XCMD, 32'h0);
	endtask : t_jog
	task t_y();
		w(`AMCI_OFF_YCMD, 32'h8);
		poll(`AMCI_OFF_YSTAT, `AMCI_S_MOVING, 1'b1);
		`CHK("y jog positive", 2'h2, {d[`AMCI_S_MOVING], d[`AMCI_S_NEG]})
		w(`AMCI_OFF_YCMD, 32'h0);
		poll(`AMCI_OFF_YSTAT, `AMCI_S_MOVING, 1'b0);
		`CHK("y jog release", 1'b0, d[`AMCI_S_MOVING])
	endtask : t_y
	task t_opt_preset();
		opt_in_pins <= 5'h15;
		repeat (8) @(posedge aclk);
		rq(`AMCI_OFF_TASK2);
		`CHK("optional inputs", 5'h15, d[15:11])
		w(`AMCI_OFF_EXPOUT, 32'h1234);
		w(`AMCI_OFF_YCMD, 32'h20);
		poll(`AMCI_OFF_YSTAT, `AMCI_S_NO_ORIGIN, 1'b0);
		`CHK("preset fixes origin", 1'b0, d[`AMCI_S_NO_ORIGIN])
		w(`AMCI_OFF_YCMD, 32'h0);
		exp_read_done <= 1'b1;
		w(`AMCI_OFF_COMMON, 32'h8000);
		repeat (8) @(posedge aclk);
		rq(`AMCI_OFF_EXPIN);
		`CHK("preset position", 16'h1234, d[15:0])
		w(`AMCI_OFF_COMMON, 32'h0);
		w(`AMCI_OFF_EXPOUT, 32'h77);
		w(`AMCI_OFF_YCMD, 32'h20);
		repeat (20) @(posedge aclk);
		rq(`AMCI_OFF_EXPIN);
		`CHK("input copy kept", 16'h1234, d[15:0])
	endtask : t_opt_preset
	task t_abs();
		w(`AMCI_OFF_YCMD, 32'h0);
		w(`AMCI_OFF_CFG, 32'h4);
		w(`AMCI_OFF_ENV, 32'h8);
		w(`AMCI_OFF_YCMD, 32'h40);
		poll(`AMCI_OFF_YSTAT, `AMCI_S_ERROR, 1'b1);
		`CHK("init under servo lock", 1'b1, d[`AMCI_S_ERROR])
		w(`AMCI_OFF_YCMD, 32'h0);
		w(`AMCI_OFF_COMMON, 32'h4000);
		poll(`AMCI_OFF_YSTAT, `AMCI_S_ERROR, 1'b0);
		`CHK("init error cleared", 1'b0, d[`AMCI_S_ERROR])
		w(`AMCI_OFF_COMMON, 32'h0);
		w(`AMCI_OFF_ENV, 32'h0);
		w(`AMCI_OFF_YCMD, 32'h40);
		w(`AMCI_OFF_YCMD, 32'h0);
		w(`AMCI_OFF_COMMON, 32'h8000);
		repeat (8) @(posedge aclk);
		rq(`AMCI_OFF_EXPIN);
		`CHK("init zeroes position", 16'h0000, d[15:0])
	endtask : t_abs
	task finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	always @(posedge hang) begin
		failures++;
		finish_test();
	end
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		aresetn = 1'b0;
		opt_in_pins = 5'h0;
		exp_read_done = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_err();
		t_search();
		t_jog();
		t_y();
		t_opt_preset();
		t_abs();
		finish_test();
	end
endmodule : tb
